// >>> rtl/rtc_alarm_irq.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps

// How it works
// R1: Select 0 compares weekday, ignores date
// R2: Select 1 compares date, ignores weekday
// R3: Weekday alarm bits match any set day
// R4: Bit 0 Sunday through bit 6 Saturday
// R5: 24-hour BCD minute, hour, date compare
// R6: All unmasked fields equal sets flag
// R7: Flag set with enable pulls line low
// R8: Bit 7 masks register from comparison
// R9: All masks set fires every minute
// R10: Clock halt suppresses all alarm events
// R11: Alarm registers double as plain storage
// R12: Flag stays set until zero written
// R13: Writing one to flag does nothing
// R14: Writing zero clears flag, releases line
// R15: Disabling enable releases line, keeps flag
// R16: Interrupt line is shared with others
// R17: Alarm low never times out alone
// R18: Software disables enable before programming
// R19: Present time programmed fires next time
// R20: Compare once per minute counter update
module rtc_alarm_irq (
	input  wire logic                    mclk_in,
	input  wire logic                    rst_in,
	input  wire logic                    ce_in,
	input  wire rtc_alarm_pkg::reg_req_t reg_req_in,
	output logic [rtc_alarm_pkg::DATA_W-1:0] reg_rdata_out,
	input  wire rtc_alarm_pkg::time_now_t now_in,
	input  wire logic                    minute_tick_in,
	input  wire logic                    other_irq_in,
	output logic                         clock_halt_out,
	output logic                         irq_out,
	output logic                         irq_oe_out
);
	import rtc_alarm_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] alarm_minutes;
	logic [DATA_W-1:0] alarm_hours;
	logic [DATA_W-1:0] alarm_weekday_or_date;
	logic [DATA_W-1:0] feature_select;
	logic [DATA_W-1:0] interrupt_control;
	logic              alarm_flag;
	logic              next_alarm_flag;
	logic [DATA_W-1:0] next_rdata;

	logic              wr_hit;
	logic              match;
	logic              alarm_event;
	logic              flag_clear;
	logic              alarm_irq_enable;
	logic              weekday_or_date_select;
	logic              clock_halt;
	logic              alarm_pull;
	alarm_cfg_t        cfg;

	function automatic logic writes_to(input reg_req_t req,
		input logic [ADDR_W-1:0] ofs);
		writes_to = req.wr && (req.addr == ofs);
	endfunction

	assign wr_hit                 = ce_in && reg_req_in.wr;
	assign alarm_irq_enable       = interrupt_control[ALARM_IRQ_EN_BIT];
	assign weekday_or_date_select = feature_select[WD_DATE_SEL_BIT];
	assign clock_halt             = interrupt_control[CLOCK_HALT_BIT];
	assign clock_halt_out         = clock_halt;

	// ------------------------------------------------------------
	// Alarm registers, usable as plain storage
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_minutes         <= RESET_BYTE;
			alarm_hours           <= RESET_BYTE;
			alarm_weekday_or_date <= RESET_BYTE;
		end else if (wr_hit) begin
			// Full byte kept so the registers serve as RAM too
			if (reg_req_in.addr == OFS_ALARM_MINUTES) begin
				alarm_minutes <= reg_req_in.wdata; // [R11]
			end
			if (reg_req_in.addr == OFS_ALARM_HOURS) begin
				alarm_hours <= reg_req_in.wdata; // [R11]
			end
			if (reg_req_in.addr == OFS_ALARM_WD_DATE) begin
				alarm_weekday_or_date <= reg_req_in.wdata; // [R11]
			end
		end
	end

	// ------------------------------------------------------------
	// Feature select and interrupt control
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			feature_select    <= RESET_BYTE;
			interrupt_control <= RESET_BYTE;
		end else if (wr_hit) begin
			if (reg_req_in.addr == OFS_FEATURE_SELECT) begin
				feature_select <= reg_req_in.wdata;
			end
			if (reg_req_in.addr == OFS_IRQ_CONTROL) begin
				// Clearing the enable drops only the line, not the flag
				interrupt_control <= reg_req_in.wdata & CONTROL_RW; // [R15]
			end
		end
	end

	// ------------------------------------------------------------
	// Match detection
	// ------------------------------------------------------------
	assign cfg.minutes     = alarm_minutes;
	assign cfg.hours       = alarm_hours;
	assign cfg.wd_date     = alarm_weekday_or_date;
	assign cfg.date_select = weekday_or_date_select;

	alarm_match u_match (
		.cfg_in    (cfg),
		.now_in    (now_in),
		.match_out (match)
	);

	// Only the counter update moment counts, so a setting equal to the
	// present time waits for the counters to come round again
	assign alarm_event = ce_in && minute_tick_in && match
		&& !clock_halt; // [R6] [R10] [R19] [R20]

	assign flag_clear = wr_hit && (reg_req_in.addr == OFS_EVENT_FLAGS)
		&& !reg_req_in.wdata[ALARM_FLAG_BIT]; // [R13] [R14]

	// ------------------------------------------------------------
	// Alarm flag: a new event wins over a same-cycle clear
	// ------------------------------------------------------------
	always_comb begin
		next_alarm_flag = alarm_flag; // [R12]
		if (flag_clear) begin
			next_alarm_flag = 1'b0; // [R14]
		end
		if (alarm_event) begin
			next_alarm_flag = 1'b1; // [R6]
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_flag <= 1'b0;
		end else if (ce_in) begin
			alarm_flag <= next_alarm_flag;
		end
	end

	// ------------------------------------------------------------
	// Shared open-drain interrupt line
	// ------------------------------------------------------------
	// No timer here: the low holds as long as flag and enable do
	assign alarm_pull = alarm_flag && alarm_irq_enable; // [R7] [R15] [R17]
	assign irq_oe_out = alarm_pull || other_irq_in; // [R16]
	assign irq_out    = 1'b0;

	// ------------------------------------------------------------
	// Read path, data one cycle after the strobe
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = ZERO_BYTE;
		unique case (reg_req_in.addr)
			OFS_CLOCK_MINUTES:  next_rdata = now_in.minutes & MINUTE_FIELD;
			OFS_CLOCK_HOURS:    next_rdata = now_in.hours & HOUR_FIELD;
			OFS_CLOCK_WEEKDAY:  next_rdata = now_in.weekday & WEEKDAY_FIELD;
			OFS_CLOCK_DATE:     next_rdata = now_in.date & DATE_FIELD;
			OFS_ALARM_MINUTES:  next_rdata = alarm_minutes;
			OFS_ALARM_HOURS:    next_rdata = alarm_hours;
			OFS_ALARM_WD_DATE:  next_rdata = alarm_weekday_or_date;
			OFS_FEATURE_SELECT: next_rdata = feature_select;
			OFS_EVENT_FLAGS: begin
				next_rdata[ALARM_FLAG_BIT] = alarm_flag;
			end
			OFS_IRQ_CONTROL:    next_rdata = interrupt_control;
			default:            next_rdata = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= ZERO_BYTE;
		end else if (ce_in) begin
			// Holds old data outside reads; master samples only after rd
			if (reg_req_in.rd) begin
				reg_rdata_out <= next_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic all_masked;
	assign all_masked = alarm_minutes[COMPARE_MASK_BIT]
		&& alarm_hours[COMPARE_MASK_BIT]
		&& alarm_weekday_or_date[COMPARE_MASK_BIT];

	logic min_ok;
	logic hour_ok;
	// Restated field compares so the checks do not lean on the matcher
	assign min_ok  = alarm_minutes[COMPARE_MASK_BIT]
		|| ((alarm_minutes & MINUTE_FIELD) == (now_in.minutes & MINUTE_FIELD));
	assign hour_ok = alarm_hours[COMPARE_MASK_BIT]
		|| ((alarm_hours & HOUR_FIELD) == (now_in.hours & HOUR_FIELD));

	a_flag_on_match: assert property (@(posedge mclk_in) // [R6]
		disable iff (rst_in)
		ce_in && minute_tick_in && match && !clock_halt |=> alarm_flag)
		else $error("alarm flag not set on match");

	a_halt_blocks_event: assert property (@(posedge mclk_in) // [R10]
		disable iff (rst_in)
		ce_in && clock_halt && !alarm_flag && !writes_to(reg_req_in,
		OFS_IRQ_CONTROL) |=> !alarm_flag)
		else $error("alarm fired while clock halted");

	a_flag_sticky: assert property (@(posedge mclk_in) // [R12]
		disable iff (rst_in)
		alarm_flag && !flag_clear |=> alarm_flag)
		else $error("alarm flag dropped without a clear");

	a_write_one_noop: assert property (@(posedge mclk_in) // [R13]
		disable iff (rst_in)
		ce_in && writes_to(reg_req_in, OFS_EVENT_FLAGS)
		&& reg_req_in.wdata[ALARM_FLAG_BIT] && !alarm_flag && !alarm_event
		|=> !alarm_flag)
		else $error("writing one changed the alarm flag");

	a_clear_releases: assert property (@(posedge mclk_in) // [R14]
		disable iff (rst_in)
		flag_clear && !alarm_event |=> !alarm_flag && !alarm_pull)
		else $error("flag clear did not release the line");

	a_enable_off_keeps: assert property (@(posedge mclk_in) // [R15]
		disable iff (rst_in)
		ce_in && writes_to(reg_req_in, OFS_IRQ_CONTROL)
		&& !reg_req_in.wdata[ALARM_IRQ_EN_BIT]
		|=> !alarm_pull && alarm_flag == $past(next_alarm_flag))
		else $error("enable clear mishandled line or flag");

	a_line_follows_flag: assert property (@(posedge mclk_in) // [R7] [R17]
		disable iff (rst_in)
		alarm_flag && alarm_irq_enable |-> irq_oe_out && !irq_out)
		else $error("interrupt line not pulled for alarm");

	a_shared_line: assert property (@(posedge mclk_in) // [R16]
		disable iff (rst_in)
		other_irq_in && !alarm_irq_enable |-> irq_oe_out)
		else $error("other source could not pull the line");

	a_every_minute: assert property (@(posedge mclk_in) // [R9]
		disable iff (rst_in)
		ce_in && minute_tick_in && all_masked && !clock_halt |=> alarm_flag)
		else $error("fully masked alarm missed a minute");

	a_weekday_any_day: assert property (@(posedge mclk_in) // [R3] [R4]
		disable iff (rst_in)
		ce_in && minute_tick_in && !clock_halt && !weekday_or_date_select
		&& min_ok && hour_ok
		&& ((alarm_weekday_or_date & now_in.weekday & WEEKDAY_FIELD)
		!= ZERO_BYTE) |=> alarm_flag)
		else $error("weekday bit match missed");

	a_date_mismatch: assert property (@(posedge mclk_in) // [R2] [R5]
		disable iff (rst_in)
		ce_in && weekday_or_date_select && !alarm_flag
		&& !alarm_weekday_or_date[COMPARE_MASK_BIT]
		&& ((alarm_weekday_or_date & DATE_FIELD) != (now_in.date & DATE_FIELD))
		&& !writes_to(reg_req_in, OFS_ALARM_WD_DATE)
		&& !writes_to(reg_req_in, OFS_FEATURE_SELECT) |=> !alarm_flag)
		else $error("date mismatch raised the alarm");

	a_no_tick_no_event: assert property (@(posedge mclk_in) // [R19] [R20]
		disable iff (rst_in)
		!minute_tick_in && !alarm_flag |=> !alarm_flag)
		else $error("alarm fired outside a counter update");

	a_storage_readback: assert property (@(posedge mclk_in) // [R11]
		disable iff (rst_in)
		ce_in && reg_req_in.rd && reg_req_in.addr == OFS_ALARM_MINUTES
		|=> reg_rdata_out == $past(alarm_minutes))
		else $error("alarm register read back wrong");

	a_mask_bit_wild: assert property (@(posedge mclk_in) // [R8]
		disable iff (rst_in)
		ce_in && minute_tick_in && !clock_halt && all_masked |-> match)
		else $error("masked fields still compared");

	a_pull_needs_enable: assert property (@(posedge mclk_in) // [R15]
		disable iff (rst_in)
		!alarm_irq_enable && !other_irq_in |-> !irq_oe_out)
		else $error("line pulled with alarm enable off");

	a_pull_needs_flag: assert property (@(posedge mclk_in) // [R14]
		disable iff (rst_in)
		!alarm_flag && !other_irq_in |-> !irq_oe_out)
		else $error("line pulled with alarm flag clear");

	a_line_holds: assert property (@(posedge mclk_in) // [R17]
		disable iff (rst_in)
		alarm_pull && !flag_clear
		&& !(ce_in && writes_to(reg_req_in, OFS_IRQ_CONTROL)) |=> alarm_pull)
		else $error("alarm pull dropped by itself");

	a_rise_needs_match: assert property (@(posedge mclk_in) // [R6]
		disable iff (rst_in)
		$rose(alarm_flag) |-> $past(match))
		else $error("alarm flag rose without a match");

	a_rise_needs_tick: assert property (@(posedge mclk_in) // [R20]
		disable iff (rst_in)
		$rose(alarm_flag) |-> $past(ce_in && minute_tick_in))
		else $error("alarm flag rose without a counter update");

	a_halt_no_rise: assert property (@(posedge mclk_in) // [R10]
		disable iff (rst_in)
		$rose(alarm_flag) |-> !$past(clock_halt))
		else $error("alarm flag rose while halted");

	a_flag_readback: assert property (@(posedge mclk_in) // [R12]
		disable iff (rst_in)
		ce_in && reg_req_in.rd && reg_req_in.addr == OFS_EVENT_FLAGS
		|=> reg_rdata_out[ALARM_FLAG_BIT] == $past(alarm_flag))
		else $error("alarm flag read back wrong");

	a_minutes_mismatch: assert property (@(posedge mclk_in) // [R5]
		disable iff (rst_in)
		ce_in && !alarm_flag && !min_ok |=> !alarm_flag)
		else $error("minute mismatch raised the alarm");

	a_hours_mismatch: assert property (@(posedge mclk_in) // [R5]
		disable iff (rst_in)
		ce_in && !alarm_flag && !hour_ok |=> !alarm_flag)
		else $error("hour mismatch raised the alarm");

	a_weekday_miss: assert property (@(posedge mclk_in) // [R1] [R3]
		disable iff (rst_in)
		ce_in && !alarm_flag && !weekday_or_date_select
		&& !alarm_weekday_or_date[COMPARE_MASK_BIT]
		&& ((alarm_weekday_or_date & now_in.weekday & WEEKDAY_FIELD)
		== ZERO_BYTE) |=> !alarm_flag)
		else $error("unselected weekday raised the alarm");

	a_date_hit: assert property (@(posedge mclk_in) // [R2]
		disable iff (rst_in)
		ce_in && minute_tick_in && !clock_halt && weekday_or_date_select
		&& min_ok && hour_ok
		&& ((alarm_weekday_or_date & DATE_FIELD) == (now_in.date & DATE_FIELD))
		|=> alarm_flag)
		else $error("date match missed");

	a_ce_holds_flag: assert property (@(posedge mclk_in) // [R12]
		disable iff (rst_in)
		!ce_in |=> $stable(alarm_flag))
		else $error("alarm flag moved while frozen");

	a_ce_holds_alarm: assert property (@(posedge mclk_in) // [R11]
		disable iff (rst_in)
		!ce_in |=> $stable(alarm_minutes))
		else $error("alarm register moved while frozen");

endmodule

// >>> rtl/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

	// ------------------------------------------------------------
	// Register port geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CLOCK_MINUTES  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_HOURS    = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_WEEKDAY  = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_CLOCK_DATE     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_ALARM_MINUTES  = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_ALARM_HOURS    = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_ALARM_WD_DATE  = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_FEATURE_SELECT = 4'hD;
	localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS    = 4'hE;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL    = 4'hF;

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int COMPARE_MASK_BIT  = 7;
	localparam int WD_DATE_SEL_BIT   = 6;
	localparam int ALARM_FLAG_BIT    = 3;
	localparam int ALARM_IRQ_EN_BIT  = 3;
	localparam int CLOCK_HALT_BIT    = 1;

	localparam logic [DATA_W-1:0] MINUTE_FIELD  = 8'h7F;
	localparam logic [DATA_W-1:0] HOUR_FIELD    = 8'h3F;
	localparam logic [DATA_W-1:0] WEEKDAY_FIELD = 8'h7F;
	localparam logic [DATA_W-1:0] DATE_FIELD    = 8'h3F;
	localparam logic [DATA_W-1:0] CONTROL_RW    = 8'hFA;
	localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
	localparam logic [DATA_W-1:0] RESET_BYTE    = 8'h00;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] minutes;
		logic [DATA_W-1:0] hours;
		logic [DATA_W-1:0] weekday;
		logic [DATA_W-1:0] date;
	} time_now_t;

	typedef struct packed {
		logic [DATA_W-1:0] minutes;
		logic [DATA_W-1:0] hours;
		logic [DATA_W-1:0] wd_date;
		logic              date_select;
	} alarm_cfg_t;

endpackage

// >>> rtl/alarm_match.sv
`timescale 1ns/1ps

module alarm_match (
	input  wire rtc_alarm_pkg::alarm_cfg_t cfg_in,
	input  wire rtc_alarm_pkg::time_now_t  now_in,
	output logic                           match_out
);
	import rtc_alarm_pkg::*;

	// Masked BCD field equality; a set mask bit always matches
	function automatic logic field_hit(input logic [DATA_W-1:0] alarm,
		input logic [DATA_W-1:0] now, input logic [DATA_W-1:0] field);
		field_hit = alarm[COMPARE_MASK_BIT] ||
			((alarm & field) == (now & field)); // [R5] [R8]
	endfunction

	logic wd_hit;
	logic day_hit;

	always_comb begin
		// Weekday alarm is a set of days, counter is one bit per day
		wd_hit  = cfg_in.wd_date[COMPARE_MASK_BIT] ||
			((cfg_in.wd_date & now_in.weekday & WEEKDAY_FIELD)
			!= ZERO_BYTE); // [R3] [R4]
		day_hit = field_hit(cfg_in.wd_date, now_in.date, DATE_FIELD);
		match_out = field_hit(cfg_in.minutes, now_in.minutes, MINUTE_FIELD)
			&& field_hit(cfg_in.hours, now_in.hours, HOUR_FIELD)
			&& (cfg_in.date_select ? day_hit : wd_hit); // [R1] [R2] [R9]
	end

endmodule

// >>> verification/host_model.sv
`timescale 1ns/1ps

module host_model (
	input  wire logic                         mclk_in,
	input  wire logic [rtc_alarm_pkg::DATA_W-1:0] rdata_in,
	input  wire logic                         irq_data_in,
	input  wire logic                         irq_oe_in,
	output rtc_alarm_pkg::reg_req_t           req_out,
	output logic                              irq_line_out
);
	import rtc_alarm_pkg::*;

	// ----------------------------------------
	// Open-drain line with pull-up
	// ----------------------------------------
	// Other sources already folded into the enable
	assign irq_line_out = irq_oe_in ? irq_data_in : 1'b1;

	initial req_out = '0;

	// ----------------------------------------
	// Register port master
	// ----------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk_in);
		req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		req_out <= '0;
		// Hand back once the write has landed in the registers
		@(negedge mclk_in);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge mclk_in);
		req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_in);
		req_out <= '0;
		@(posedge mclk_in);
		d = rdata_in;
	endtask
endmodule

// >>> verification/test_rtc_alarm_irq.sv
`timescale 1ns/1ps

module test_rtc_alarm_irq;
	import rtc_alarm_pkg::*;

	logic       mclk_in = 1'b0;
	logic       rst_in  = 1'b1;
	logic       ce_in   = 1'b1;
	logic       tick    = 1'b0;
	logic       other   = 1'b0;
	time_now_t  now     = '0;
	reg_req_t   req;
	logic [7:0] rdata;
	logic       halt;
	logic       irq_d;
	logic       irq_oe;
	logic       line;
	int         error_cnt   = 0;
	int         check_count = 0;

	always #20 mclk_in = ~mclk_in;

	rtc_alarm_irq dut (
		.mclk_in       (mclk_in),
		.rst_in        (rst_in),
		.ce_in         (ce_in),
		.reg_req_in    (req),
		.reg_rdata_out (rdata),
		.now_in        (now),
		.minute_tick_in(tick),
		.other_irq_in  (other),
		.clock_halt_out(halt),
		.irq_out       (irq_d),
		.irq_oe_out    (irq_oe)
	);

	host_model host (
		.mclk_in     (mclk_in),
		.rdata_in    (rdata),
		.irq_data_in (irq_d),
		.irq_oe_in   (irq_oe),
		.req_out     (req),
		.irq_line_out(line)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk("register", e, d);
	endtask

	// New minute shown with one tick pulse
	task automatic step(input time_now_t t);
		@(posedge mclk_in);
		now  <= t;
		tick <= 1'b1;
		@(posedge mclk_in);
		tick <= 1'b0;
		@(posedge mclk_in);
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk(OFS_EVENT_FLAGS, 8'h00);
		host.wr(OFS_EVENT_FLAGS, 8'h08);
		rchk(OFS_EVENT_FLAGS, 8'h00);
		rchk(OFS_IRQ_CONTROL, 8'h00);
		rchk(4'hB, 8'h00);
		chk("irq_line", 8'h01, {7'h00, line});
	endtask

	task automatic t_storage;
		host.wr(OFS_IRQ_CONTROL, 8'h00);
		host.wr(OFS_ALARM_MINUTES, 8'hA5);
		host.wr(OFS_ALARM_HOURS, 8'h5A);
		host.wr(OFS_ALARM_WD_DATE, 8'hFF);
		rchk(OFS_ALARM_MINUTES, 8'hA5);
		rchk(OFS_ALARM_HOURS, 8'h5A);
		rchk(OFS_ALARM_WD_DATE, 8'hFF);
		// Frozen cycle: the write must not land
		@(posedge mclk_in);
		ce_in <= 1'b0;
		host.wr(OFS_ALARM_MINUTES, 8'h3C);
		@(posedge mclk_in);
		ce_in <= 1'b1;
		rchk(OFS_ALARM_MINUTES, 8'hA5);
	endtask

	task automatic t_arm;
		host.wr(OFS_IRQ_CONTROL, 8'h00);
		host.wr(OFS_ALARM_MINUTES, 8'h30);
		host.wr(OFS_ALARM_HOURS, 8'h07);
		host.wr(OFS_ALARM_WD_DATE, 8'h80);
		host.wr(OFS_IRQ_CONTROL, 8'h08);
		@(posedge mclk_in);
		now <= '{minutes: 8'h30, hours: 8'h07, weekday: 8'h01, date: 8'h01};
		rchk(OFS_EVENT_FLAGS, 8'h00);
		chk("irq_line", 8'h01, {7'h00, line});
		step('{minutes: 8'h30, hours: 8'h07, weekday: 8'h01, date: 8'h01});
		rchk(OFS_EVENT_FLAGS, 8'h08);
		chk("irq_line", 8'h00, {7'h00, line});
	endtask

	task automatic t_hold;
		host.wr(OFS_EVENT_FLAGS, 8'h08);
		repeat (20) @(posedge mclk_in);
		rchk(OFS_EVENT_FLAGS, 8'h08);
		chk("irq_line", 8'h00, {7'h00, line});
		host.wr(OFS_IRQ_CONTROL, 8'h00);
		chk("irq_line", 8'h01, {7'h00, line});
		rchk(OFS_EVENT_FLAGS, 8'h08);
		host.wr(OFS_IRQ_CONTROL, 8'h08);
		chk("irq_line", 8'h00, {7'h00, line});
		host.wr(OFS_EVENT_FLAGS, 8'h00);
		chk("irq_line", 8'h01, {7'h00, line});
		rchk(OFS_EVENT_FLAGS, 8'h00);
	endtask

	// Date field set to the alarm byte so a date compare would match
	task automatic t_weekday;
		host.wr(OFS_IRQ_CONTROL, 8'h00);
		host.wr(OFS_FEATURE_SELECT, 8'h00);
		host.wr(OFS_ALARM_MINUTES, 8'h80);
		host.wr(OFS_ALARM_HOURS, 8'h07);
		host.wr(OFS_ALARM_WD_DATE, 8'h2A);
		for (int d = 0; d < 7; d++) begin
			step('{minutes: 8'h00, hours: 8'h07, weekday: 8'h01 << d, date: 8'h2A});
			rchk(OFS_EVENT_FLAGS, d % 2 ? 8'h08 : 8'h00);
			host.wr(OFS_EVENT_FLAGS, 8'h00);
		end
		step('{minutes: 8'h00, hours: 8'h17, weekday: 8'h02, date: 8'h2A});
		rchk(OFS_EVENT_FLAGS, 8'h00);
	endtask

	task automatic t_date;
		host.wr(OFS_FEATURE_SELECT, 8'h40);
		host.wr(OFS_ALARM_WD_DATE, 8'h15);
		rchk(OFS_FEATURE_SELECT, 8'h40);
		step('{minutes: 8'h00, hours: 8'h07, weekday: 8'h00, date: 8'h15});
		rchk(OFS_EVENT_FLAGS, 8'h08);
		host.wr(OFS_EVENT_FLAGS, 8'h00);
		step('{minutes: 8'h00, hours: 8'h07, weekday: 8'h15, date: 8'h14});
		rchk(OFS_EVENT_FLAGS, 8'h00);
	endtask

	task automatic t_masks;
		host.wr(OFS_ALARM_HOURS, 8'h80);
		host.wr(OFS_ALARM_WD_DATE, 8'h80);
		step('{minutes: 8'h59, hours: 8'h23, weekday: 8'h40, date: 8'h31});
		rchk(OFS_EVENT_FLAGS, 8'h08);
		host.wr(OFS_EVENT_FLAGS, 8'h00);
	endtask

	task automatic t_halt;
		host.wr(OFS_IRQ_CONTROL, 8'h0A);
		chk("clock_halt", 8'h01, {7'h00, halt});
		step('{minutes: 8'h01, hours: 8'h00, weekday: 8'h01, date: 8'h01});
		rchk(OFS_EVENT_FLAGS, 8'h00);
		chk("irq_line", 8'h01, {7'h00, line});
		host.wr(OFS_IRQ_CONTROL, 8'h00);
	endtask

	task automatic t_shared;
		@(posedge mclk_in);
		other <= 1'b1;
		@(posedge mclk_in);
		chk("irq_line", 8'h00, {7'h00, line});
		other <= 1'b0;
		@(posedge mclk_in);
		chk("irq_line", 8'h01, {7'h00, line});
	endtask

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset();
		t_storage();
		t_arm();
		t_hold();
		t_weekday();
		t_date();
		t_masks();
		t_halt();
		t_shared();
		wrap_up();
	end

	initial begin
		repeat (5000) @(posedge mclk_in);
		error_cnt++;
		wrap_up();
	end
endmodule
